// ==== hdl/cctmr_top.sv ====
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// RULE1: Seven prescaled rates chosen by prescale_select.
// RULE2: Active capture edge copies counter into channel.
// RULE3: Capture sets channel flag and interrupt request.
// RULE4: Compare match sets, clears or toggles pin.
// RULE5: Compare match sets channel flag and request.
// RULE6: Unbuffered writes replace compare value immediately.
// RULE7: Software times unbuffered writes by interrupts.
// RULE8: link_buffered_select links channels onto channel 0.
// RULE9: Last written channel takes over at overflow.
// RULE10: Channel 1 control unused, pin released.
// RULE11: Software writes only the inactive channel.
// RULE12: Toggle-on-overflow toggles pin at modulo.
// RULE13: Pulse width runs overflow to compare.
// RULE14: Period is modulo plus one ticks.
// RULE15: Software avoids toggle on compare in PWM.
// RULE16: Software follows the PWM initialisation order.
// RULE17: Halt stops counter; reset clears counter, prescaler.
// RULE18: Toggle-on-overflow cleared gives zero duty.
// RULE19: Max-duty with toggle-on-overflow gives full duty.
// RULE20: At modulo set overflow flag, restart at zero.
// RULE21: Codes 0 to 6 divide by 1 to 64.
// RULE22: Counter, modulo and values are 16 bits.
module cctmr_top
    import cctmr_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    // Register port.
    input wire logic [3:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [15:0] RDATA_OUT,
    // Channel pins.
    input wire logic [1:0] CHAN_PIN_IN,
    output logic [1:0] CHAN_PIN_OUT,
    output logic [1:0] CHAN_PIN_OE_OUT,
    // Interrupt requests, one per channel plus overflow.
    output logic [1:0] CHAN_IRQ_OUT,
    output logic OVF_IRQ_OUT
);

    // Every register of the block lives in this one struct, so a single process
    // owns all state. Field order does not matter; the reset assignment below sets fields by name.
    // The channel control bytes keep the flag in bit 7 and the enable in bit 6.
    // The synchroniser stages sit here as well, so reset clears them together.
    typedef struct packed {
        logic [5:0] presc;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] modv;
        logic [7:0] timer_status_ctrl;
        logic [1:0][7:0] csc;
        logic [1:0][CNT_W-1:0] val;
        logic active1;
        logic last1;
        logic [1:0] pin;
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] prev;
        logic [15:0] rdata;
        logic [1:0] irq;
        logic ovirq;
        logic [1:0] oe;
    } cctmr_state_s;

    cctmr_state_s s_q;
    cctmr_state_s s_d;

    logic tick;
    logic at_mod;
    logic linked;

    // Prescaler tap selection; the counter only moves on the chosen enable.
    // The prescaler is a six-bit count that runs while not halted, and each rate is the cycle in
    // which its low bits are all ones, so every rate is a one-cycle enable pulse.
    // Sharing one count keeps the rates in phase after a counter reset.
    always_comb begin
        case (s_q.timer_status_ctrl[2:0])
            3'h0: tick = 1'b1; // RULE21
            3'h1: tick = s_q.presc[0];
            3'h2: tick = &s_q.presc[1:0];
            3'h3: tick = &s_q.presc[2:0];
            3'h4: tick = &s_q.presc[3:0];
            3'h5: tick = &s_q.presc[4:0];
            3'h6: tick = &s_q.presc[5:0]; // RULE1
            default: tick = 1'b0; // Code seven is not available, counter idles.
        endcase
        tick = tick & ~s_q.timer_status_ctrl[CCTMR_TSC_HALT];
    end

    // Overflow is decoded from the held count; a modulo written below the count
    // is only seen after the counter wraps past the full 16-bit range.
    assign at_mod = (s_q.cnt == s_q.modv); // RULE22
    assign linked = s_q.csc[0][CCTMR_CSC_MSB];

    // All next-state logic in one place.
    always_comb begin
        logic [CNT_W-1:0] cmpv;
        logic match;
        logic edge_hit;
        logic rise;
        logic fall;
        logic wr1;
        logic wr0;
        logic [CNT_W-1:0] nxt;
        logic [1:0] setf;
        cmpv = '0;
        nxt = '0;
        setf = 2'b00;
        match = 1'b0;
        edge_hit = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        wr1 = 1'b0;
        wr0 = 1'b0;
        s_d = s_q;
        // Pins pass two flip-flops before the edge detector reads them; only the
        // second stage feeds logic, which keeps metastability out of the captures.
        s_d.sync1 = CHAN_PIN_IN;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        s_d.rdata = 16'h0000;

        // Prescaler runs while the counter is not halted.
        // Halting freezes the prescaler as well, so a resumed counter keeps the
        // phase it stopped with.
        if (!s_q.timer_status_ctrl[CCTMR_TSC_HALT]) begin
            s_d.presc = s_q.presc + 6'h01;
        end

        // The value the counter takes at this edge; compares look at it so that a
        // pulse lasts exactly the channel value in timer clocks, not one more.
        nxt = at_mod ? '0 : s_q.cnt + CNT_W'(1);

        // Counter advance and overflow handling.
        if (tick) begin
            if (at_mod) begin
                s_d.cnt = '0; // RULE20
                s_d.timer_status_ctrl[CCTMR_TSC_OVF] = 1'b1; // RULE20
                s_d.active1 = s_q.last1; // RULE9
            end else begin
                s_d.cnt = s_q.cnt + 1'b1; // RULE14
            end
        end

        // Per-channel capture and compare; channel 1 is idle while linked.
        // Compares look at the count the counter is about to take, so a pulse that
        // begins at overflow lasts the channel value in timer clocks. A value above
        // the modulo never matches, so such a pulse covers the whole period.
        for (int i = 0; i < 2; i++) begin
            if (!(i == 1 && linked)) begin // RULE10
                if (s_q.csc[i][CCTMR_CSC_MSB] || s_q.csc[i][CCTMR_CSC_MSA]) begin
                    // Linked pair uses whichever value is active.
                    // Channel 1's value only takes over at an overflow boundary.
                    cmpv = (i == 0 && linked && s_q.active1) ? s_q.val[1] : s_q.val[i]; // RULE9
                    match = tick && (nxt == cmpv); // RULE6
                    if (match) begin
                        s_d.csc[i][CCTMR_CSC_FLAG] = 1'b1; // RULE5
                        setf[i] = 1'b1;
                        // Full duty suppresses the compare action.
                        if (!(s_q.csc[i][CCTMR_CSC_MAX] && s_q.csc[i][CCTMR_CSC_TOV])) begin
                            case (s_q.csc[i][3:2])
                                2'h1: s_d.pin[i] = ~s_q.pin[i]; // RULE4
                                2'h2: s_d.pin[i] = 1'b0; // RULE13
                                2'h3: s_d.pin[i] = 1'b1; // RULE4
                                default: s_d.pin[i] = s_q.pin[i];
                            endcase
                        end
                    end
                    // Overflow toggling; compares then only restore the level.
                    // When compare and overflow fall on one edge the compare wins,
                    // which is what gives a zero value its clean zero duty.
                    if (tick && at_mod && s_q.csc[i][CCTMR_CSC_TOV]) begin // RULE18
                        if (s_q.csc[i][CCTMR_CSC_MAX]) begin
                            s_d.pin[i] = (s_q.csc[i][3:2] == 2'h3) ? 1'b0 : 1'b1; // RULE19
                        end else if (!match) begin
                            s_d.pin[i] = ~s_q.pin[i]; // RULE12
                        end
                    end
                    s_d.oe[i] = (s_q.csc[i][3:2] != 2'h0);
                end else begin
                    // Input capture on the synchronised pin.
                    // The edge detector's reset level matches an idle low pin, so no
                    // false edge follows reset.
                    rise = s_q.sync2[i] & ~s_q.prev[i];
                    fall = ~s_q.sync2[i] & s_q.prev[i];
                    edge_hit = (rise & s_q.csc[i][CCTMR_CSC_ELSA]) |
                               (fall & s_q.csc[i][CCTMR_CSC_ELSB]);
                    if (edge_hit) begin
                        s_d.val[i] = s_q.cnt; // RULE2
                        s_d.csc[i][CCTMR_CSC_FLAG] = 1'b1; // RULE3
                        setf[i] = 1'b1;
                    end
                    s_d.oe[i] = 1'b0;
                end
            end else begin
                s_d.oe[i] = 1'b0; // RULE10
            end
        end

        // Register writes; a flag clear loses to a set in the same cycle.
        // Flags clear by a write of zero to bit 7 with no read step first; a set in
        // the same cycle wins, so an event is never lost to a late clear.
        // The counter reset bit acts for one write and is never stored.
        // Channel 1 cannot take the link bit, which belongs to channel 0 alone.
        if (WR_IN) begin
            case (ADDR_IN)
                CCTMR_OFF_TIMER_STATUS_CTRL: begin
                    s_d.timer_status_ctrl[6:0] = {WDATA_IN[6:5], 2'b00, WDATA_IN[2:0]};
                    if (!WDATA_IN[CCTMR_TSC_OVF] && !s_d.timer_status_ctrl[CCTMR_TSC_OVF] == 1'b0
                        && !(tick && at_mod)) begin
                        s_d.timer_status_ctrl[CCTMR_TSC_OVF] = 1'b0;
                    end
                    if (WDATA_IN[CCTMR_TSC_CRST]) begin
                        s_d.cnt = '0; // RULE17
                        s_d.presc = '0; // RULE17
                    end
                end
                CCTMR_OFF_MODULO_REGS: s_d.modv = WDATA_IN[CNT_W-1:0];
                CCTMR_OFF_CHAN0_STATUS_CTRL: begin
                    s_d.csc[0][6:0] = WDATA_IN[6:0]; // RULE8
                    if (!WDATA_IN[CCTMR_CSC_FLAG] && !setf[0]) begin
                        s_d.csc[0][CCTMR_CSC_FLAG] = 1'b0;
                    end
                end
                CCTMR_OFF_CHAN1_STATUS_CTRL: begin
                    s_d.csc[1][6:0] = {WDATA_IN[6], 1'b0, WDATA_IN[4:0]};
                    if (!WDATA_IN[CCTMR_CSC_FLAG] && !setf[1]) begin
                        s_d.csc[1][CCTMR_CSC_FLAG] = 1'b0;
                    end
                end
                CCTMR_OFF_CHAN0_VALUE: wr0 = 1'b1;
                CCTMR_OFF_CHAN1_VALUE: wr1 = 1'b1;
                default: ;
            endcase
        end
        // A write to the active value acts at once, as unbuffered operation does;
        // the last written channel is remembered for the next overflow.
        if (wr0) begin
            s_d.val[0] = WDATA_IN[CNT_W-1:0]; // RULE6
            s_d.last1 = 1'b0; // RULE9
        end
        if (wr1) begin
            s_d.val[1] = WDATA_IN[CNT_W-1:0];
            s_d.last1 = 1'b1; // RULE9
        end
        // Unlinked channels never hand over, so the hand-over state is held clear
        // and a later link always starts from channel 0.
        if (!linked) begin
            s_d.active1 = 1'b0; // RULE8
            s_d.last1 = 1'b0;
        end

        // Read data stands in the cycle after the strobe.
        // Outside a read the data lines stay at zero, so a stale value is never
        // mistaken for an answer.
        if (RD_IN) begin
            case (ADDR_IN)
                CCTMR_OFF_TIMER_STATUS_CTRL: s_d.rdata = {8'h00, s_q.timer_status_ctrl[7:5], 2'b00, s_q.timer_status_ctrl[2:0]};
                CCTMR_OFF_COUNTER: s_d.rdata = s_q.cnt;
                CCTMR_OFF_MODULO_REGS: s_d.rdata = s_q.modv;
                CCTMR_OFF_CHAN0_STATUS_CTRL: s_d.rdata = {7'h00, s_q.active1, s_q.csc[0]};
                CCTMR_OFF_CHAN0_VALUE: s_d.rdata = s_q.val[0];
                CCTMR_OFF_CHAN1_STATUS_CTRL: s_d.rdata = {8'h00, s_q.csc[1]};
                CCTMR_OFF_CHAN1_VALUE: s_d.rdata = s_q.val[1];
                default: s_d.rdata = 16'h0000;
            endcase
        end

        // Requests follow flag and enable.
        // They use the next flag values, so a request rises in the same cycle as
        // its flag and falls with the clear.
        for (int i = 0; i < 2; i++) begin
            s_d.irq[i] = s_d.csc[i][CCTMR_CSC_FLAG] & s_d.csc[i][CCTMR_CSC_IE]; // RULE5
        end
        s_d.ovirq = s_d.timer_status_ctrl[CCTMR_TSC_OVF] & s_d.timer_status_ctrl[CCTMR_TSC_OVIE];
    end

    // State register; the counter starts halted with the modulo at maximum.
    // Reset loads constants only; the control byte reset value keeps the counter
    // stopped until software has set it up.
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s_q <= '0;
            s_q.timer_status_ctrl <= CCTMR_TSC_RESET;
            s_q.modv <= CCTMR_MODULO_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    // No logic sits between these flip-flops and the ports, which keeps the pin
    // timing independent of the decode above.
    assign RDATA_OUT = s_q.rdata;
    assign CHAN_PIN_OUT = s_q.pin;
    assign CHAN_PIN_OE_OUT = s_q.oe;
    assign CHAN_IRQ_OUT = s_q.irq;
    assign OVF_IRQ_OUT = s_q.ovirq;

endmodule // cctmr_top

// ==== hdl/cctmr_pkg.sv ====
package cctmr_pkg;

    // Register offsets on the plain register port.
    localparam logic [3:0] CCTMR_OFF_TIMER_STATUS_CTRL = 4'h0;
    localparam logic [3:0] CCTMR_OFF_COUNTER = 4'h1;
    localparam logic [3:0] CCTMR_OFF_MODULO_REGS = 4'h2;
    localparam logic [3:0] CCTMR_OFF_CHAN0_STATUS_CTRL = 4'h3;
    localparam logic [3:0] CCTMR_OFF_CHAN0_VALUE = 4'h4;
    localparam logic [3:0] CCTMR_OFF_CHAN1_STATUS_CTRL = 4'h5;
    localparam logic [3:0] CCTMR_OFF_CHAN1_VALUE = 4'h6;

    // Timer status and control field positions.
    localparam int CCTMR_TSC_OVF = 7;
    localparam int CCTMR_TSC_OVIE = 6;
    localparam int CCTMR_TSC_HALT = 5;
    localparam int CCTMR_TSC_CRST = 4;

    // Channel status and control field positions.
    localparam int CCTMR_CSC_FLAG = 7;
    localparam int CCTMR_CSC_IE = 6;
    localparam int CCTMR_CSC_MSB = 5;
    localparam int CCTMR_CSC_MSA = 4;
    localparam int CCTMR_CSC_ELSB = 3;
    localparam int CCTMR_CSC_ELSA = 2;
    localparam int CCTMR_CSC_TOV = 1;
    localparam int CCTMR_CSC_MAX = 0;

    // Values after reset, and the last valid prescale code.
    localparam logic [7:0] CCTMR_TSC_RESET = 8'h20;
    localparam logic [15:0] CCTMR_MODULO_RESET = 16'hFFFF;
    localparam logic [2:0] CCTMR_PS_LAST = 3'h6;

    // One channel's pin group.
    typedef struct packed {
        logic out;
        logic oe;
    } cctmr_pin_s;

endpackage

// ==== tb/cctmr_properties.sv ====
`timescale 1ns/1ps
// Checks port behaviour against a shadow of what software last wrote.
module cctmr_properties
    import cctmr_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock, reset and register port.
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic [15:0] RDATA_OUT,
    // Pins and requests.
    input wire logic [1:0] CHAN_PIN_IN,
    input wire logic [1:0] CHAN_PIN_OUT,
    input wire logic [1:0] CHAN_PIN_OE_OUT,
    input wire logic [1:0] CHAN_IRQ_OUT,
    input wire logic OVF_IRQ_OUT
);
    logic [6:0] tsc_q;
    logic [15:0] mod_q;
    logic [1:0] cie_q;
    logic link_q;
    logic z_q;
    // Flags are left out of the shadow because hardware sets them on its own.
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tsc_q <= CCTMR_TSC_RESET[6:0];
            mod_q <= CCTMR_MODULO_RESET;
            cie_q <= 2'b00;
            link_q <= 1'b0;
            z_q <= 1'b0;
        end else if (WR_IN) begin
            if (ADDR_IN == CCTMR_OFF_TIMER_STATUS_CTRL) begin
                tsc_q <= WDATA_IN[6:0] & 7'h67;
                z_q <= WDATA_IN[5:4] == 2'b11;
            end
            if (ADDR_IN == CCTMR_OFF_MODULO_REGS) mod_q <= WDATA_IN;
            if (ADDR_IN == CCTMR_OFF_CHAN0_STATUS_CTRL) begin
                cie_q[0] <= WDATA_IN[CCTMR_CSC_IE];
                link_q <= WDATA_IN[CCTMR_CSC_MSB];
            end
            if (ADDR_IN == CCTMR_OFF_CHAN1_STATUS_CTRL) cie_q[1] <= WDATA_IN[CCTMR_CSC_IE];
        end
    end
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    chk_read_idle: assert property (!$past(RD_IN) |-> RDATA_OUT == 16'h0000)
        else $error("read data outside a read cycle");
    chk_unmapped_zero: assert property ($past(RD_IN) && $past(ADDR_IN) > 4'h6 |-> RDATA_OUT == 16'h0000)
        else $error("unmapped read not zero");
    chk_ctrl_readback: assert property ($past(RD_IN) && $past(ADDR_IN) == CCTMR_OFF_TIMER_STATUS_CTRL
        |-> (RDATA_OUT[6:0] & 7'h77) == $past(tsc_q)) else $error("timer control read-back");
    chk_modulo_readback: assert property ($past(RD_IN) && $past(ADDR_IN) == CCTMR_OFF_MODULO_REGS
        |-> RDATA_OUT == $past(mod_q)) else $error("modulo read-back");
    chk_ch1_nolink: assert property ($past(RD_IN) && $past(ADDR_IN) == CCTMR_OFF_CHAN1_STATUS_CTRL
        |-> !RDATA_OUT[CCTMR_CSC_MSB]) else $error("channel 1 link bit set");
    chk_counter_cleared: assert property ($past(RD_IN) && $past(ADDR_IN) == CCTMR_OFF_COUNTER
        && $past(z_q) && $past(z_q, 2) |-> RDATA_OUT == 16'h0000) else $error("counter not cleared");
    chk_chan_irq_gate: assert property ((CHAN_IRQ_OUT & ~(cie_q | $past(cie_q))) == 2'b00)
        else $error("channel request without enable");
    chk_ovf_irq_gate: assert property (OVF_IRQ_OUT |-> tsc_q[6] || $past(tsc_q[6]))
        else $error("overflow request without enable");
    chk_link_release: assert property (link_q && $past(link_q, 2) |-> !CHAN_PIN_OE_OUT[1])
        else $error("channel 1 pin driven while linked");
endmodule // cctmr_properties
bind cctmr_top cctmr_properties #(.CNT_W(CNT_W)) u_props (.REF_CLK_IN(REF_CLK_IN),
    .RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .RDATA_OUT(RDATA_OUT), .CHAN_PIN_IN(CHAN_PIN_IN), .CHAN_PIN_OUT(CHAN_PIN_OUT),
    .CHAN_PIN_OE_OUT(CHAN_PIN_OE_OUT), .CHAN_IRQ_OUT(CHAN_IRQ_OUT), .OVF_IRQ_OUT(OVF_IRQ_OUT));

// ==== tb/cctmr_pin_env.sv ====
`timescale 1ns/1ps
// Event sources and loads on the two channel pins.
module cctmr_pin_env (
    // Source levels, set by the testbench.
    input wire logic [1:0] ev_in,
    // Timer pin group.
    input wire logic [1:0] drv_in,
    input wire logic [1:0] oe_in,
    output logic [1:0] pin_out
);
    // A released pin shows the source, so captures see real edges.
    assign pin_out = (oe_in & drv_in) | (~oe_in & ev_in);
endmodule // cctmr_pin_env

// ==== tb/capture_compare_pwm_timer_tb.sv ====
`timescale 1ns/1ps
`define CK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: %h %h", $time, g, e); end end
module capture_compare_pwm_timer_tb;
    import cctmr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, oirq;
    logic [3:0] addr = 4'h0;
    logic [15:0] wd = 16'h0000, r, rdata, rv;
    logic [1:0] ev = 2'b00, pin, pout, poe, cirq;
    logic [15:0] exp_q[$];
    logic [7:0] cfg[5] = '{8'h58, 8'h5B, 8'h5E, 8'h54, 8'h5A};
    int hi[5] = '{0, 100, 60, 50, 40};
    int err_total = 0, checks = 0, n;
    cctmr_top dut (.REF_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .CHAN_PIN_IN(pin), .CHAN_PIN_OUT(pout),
        .CHAN_PIN_OE_OUT(poe), .CHAN_IRQ_OUT(cirq), .OVF_IRQ_OUT(oirq));
    cctmr_pin_env env (.ev_in(ev), .drv_in(pout), .oe_in(poe), .pin_out(pin));
    initial forever #50 clk = ~clk;
    // A gap cycle after each access keeps strobes from being set twice in one step.
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        @(posedge clk);
    endtask
    // Counts high cycles on pin 0 over ten whole periods once the output has settled.
    task automatic duty;
        n = 0;
        repeat (30) @(posedge clk);
        repeat (100) begin
            @(posedge clk);
            n += int'(pout[0]);
        end
    endtask
    task automatic test_done;
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Read data are judged in the cycle after the strobe against the oldest note.
    always @(posedge clk) begin
        if (rd_d) begin
            r = exp_q.pop_front();
            `CK(rdata, r)
        end
        rd_d = rd;
    end
    initial begin
        void'($urandom(32'h8C43B580));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h0020);
        rreg(CCTMR_OFF_MODULO_REGS, CCTMR_MODULO_RESET);
        rreg(CCTMR_OFF_CHAN0_STATUS_CTRL, 16'h0000);
        wreg(4'h7, 16'hFFFF);
        rreg(4'h7, 16'h0000);
        rv = 16'($urandom);
        wreg(CCTMR_OFF_MODULO_REGS, rv);
        rreg(CCTMR_OFF_MODULO_REGS, rv);
        wreg(CCTMR_OFF_MODULO_REGS, 16'hFFFF);
        wreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h0030);
        rreg(CCTMR_OFF_COUNTER, 16'h0000);
        // Each rate counts 128 bus cycles; 128 is a multiple of every divisor.
        for (int k = 0; k < 7; k++) begin
            wreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h0030 | 16'(k));
            wreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'(k));
            repeat (126) @(posedge clk);
            wreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h0020 | 16'(k));
            rreg(CCTMR_OFF_COUNTER, 16'(128 >> k));
        end
        wreg(CCTMR_OFF_CHAN1_STATUS_CTRL, 16'h0064);
        rreg(CCTMR_OFF_CHAN1_STATUS_CTRL, 16'h0044);
        ev <= 2'b10;
        repeat (6) @(posedge clk);
        rreg(CCTMR_OFF_CHAN1_VALUE, 16'h0002);
        `CK(cirq[1], 1'b1)
        wreg(CCTMR_OFF_MODULO_REGS, 16'($urandom_range(11, 4)));
        wreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h0070);
        wreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h0040);
        n = 0;
        while (oirq !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n == 40) begin
            err_total++;
            test_done();
        end
        wreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h00E0);
        rreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h00E0);
        wreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h0060);
        rreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h0060);
        `CK(oirq, 1'b0)
        wreg(CCTMR_OFF_MODULO_REGS, 16'h0009);
        wreg(CCTMR_OFF_CHAN0_VALUE, 16'h0004);
        wreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h0030);
        wreg(CCTMR_OFF_TIMER_STATUS_CTRL, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            wreg(CCTMR_OFF_CHAN0_STATUS_CTRL, {8'h00, cfg[i]});
            duty();
            `CK(n, hi[i])
            `CK({poe[0], cirq[0]}, 2'b11)
        end
        wreg(CCTMR_OFF_CHAN0_VALUE, 16'h0006);
        duty();
        `CK(n, 60)
        wreg(CCTMR_OFF_CHAN0_STATUS_CTRL, 16'h002A);
        wreg(CCTMR_OFF_CHAN1_VALUE, 16'h0007);
        duty();
        `CK(n, 70)
        `CK(poe[1], 1'b0)
        rreg(CCTMR_OFF_CHAN0_STATUS_CTRL, 16'h01AA);
        test_done();
    end
endmodule // capture_compare_pwm_timer_tb
